// *** abt_master.sv ***
/*
  abt_master: processor end of an asynchronous multiplexed backplane
  bus. Runs queued read, word-write and byte-write transfers with sync,
  data strobes and write/byte qualifier, deskews strobes and read data,
  and services level-4/level-7 interrupts through the acknowledge chain
  and external events by internal vector. Assumes all inputs are already synchronous to
  mclk; bus lines appear as active-high levels, open-drain pins split
  into input/output/enable, the wired level formed outside.
*/
`timescale 1ns/10ps
// Operation
// - event request with status bit clear vectors
// - data-out strobe means write data valid
// - data-out strobe only after data settles
// - data-in strobe within sync requests input
// - data-in without sync is acknowledge cycle
// - read data sampled after reply plus deskew
// - sync held with address whole transfer
// - write/byte at sync marks write sequence
// - write/byte during strobe selects byte write
// - status bit clear lets level-4 acknowledged
// - separate level-7 request line exists
// - processor drives acknowledge out to chain
module abt_master
  import abt_pkg::*;
#(
  parameter int OUT_DESKEW = DESKEW_OUT_CYC,
  parameter int IN_DESKEW = DESKEW_IN_CYC,
  parameter int QDEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user request stream
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  // user response
  output logic rsp_valid,
  output logic [1:0] rsp_code,
  output logic [DATA_W-1:0] rsp_data,
  // processor status word
  input wire logic [15:0] processor_status_word,
  // data/address lines, open drain
  input wire logic [ADDR_W-1:0] data_address_lines_in,
  output logic [ADDR_W-1:0] data_address_lines_out,
  output logic data_address_lines_oe,
  // transfer strobes
  output logic transfer_sync,
  output logic data_in_strobe,
  output logic data_out_strobe,
  output logic write_byte_select,
  input wire logic slave_reply,
  // interrupts
  input wire logic irq_level_four,
  input wire logic irq_level_seven,
  input wire logic external_event_request,
  output logic int_ack_out,
  // dma arbitration
  input wire logic dma_mastership_request,
  output logic dma_grant_out,
  input wire logic dma_select_ack,
  // bus initialize
  output logic bus_initialize
);

  // refuse parameters the timer cannot hold
  initial begin
    if (OUT_DESKEW < 1 || OUT_DESKEW >= (1 << CNT_W) || IN_DESKEW < 1 || IN_DESKEW >= (1 << CNT_W)) begin
      $error("abt_master deskew counts out of range");
    end
  end

  // one-hot transfer states
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ADDR = 10'h002,
    ST_SETTLE = 10'h004,
    ST_STROBE = 10'h008,
    ST_DESKEW = 10'h010,
    ST_END = 10'h020,
    ST_IAK = 10'h040,
    ST_IAK_DESKEW = 10'h080,
    ST_DMA = 10'h100,
    ST_EVENT = 10'h200
  } abt_state_e;

  abt_state_e state_r; // transfer state
  abt_state_e state_nxt; // next transfer state
  logic [CNT_W-1:0] cnt_r; // deskew timer
  logic [REQ_W-1:0] cur_r; // request in flight
  logic [REQ_W-1:0] q_data; // fifo head
  logic q_valid; // fifo has a request
  logic q_take; // pop fifo head
  logic irq_ok; // interrupts unmasked
  logic irq_pend; // some device interrupt waits
  logic event_seen_r; // previous event level
  logic event_pend_r; // event waiting for service
  logic is_write; // in-flight request writes
  logic is_byte; // in-flight request is a byte write
  logic [1:0] cur_kind; // kind field of in-flight request

  // request queue between user and bus sequencer
  abt_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(QDEPTH)
  ) u_req_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_kind, req_addr, req_wdata}),
    .out_valid(q_valid),
    .out_ready(q_take),
    .out_data(q_data)
  );

  // decode of the in-flight request
  assign cur_kind = cur_r[REQ_W-1 -: 2];
  assign is_write = (cur_kind == KIND_WORD_WRITE) || (cur_kind == KIND_BYTE_WRITE);
  assign is_byte = (cur_kind == KIND_BYTE_WRITE);
  // priority mask from the status word
  assign irq_ok = !processor_status_word[PSW_PRIO_BIT];
  // level 7 and level 4 lines both raise service; is the device's job
  assign irq_pend = irq_ok && (irq_level_seven || irq_level_four);
  // take a queued request only from idle with no interrupt or dma waiting
  assign q_take = (state_r == ST_IDLE) && q_valid && !irq_pend && !(event_pend_r && irq_ok)
    && !dma_mastership_request;

  // event request is edge-caught so a held line vectors once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      event_seen_r <= 1'b0;
      event_pend_r <= 1'b0;
    end else begin
      event_seen_r <= external_event_request;
      // a new edge wins over the clear in the same cycle
      if (external_event_request && !event_seen_r) begin
        event_pend_r <= 1'b1;
      end else if (state_r == ST_EVENT) begin
        event_pend_r <= 1'b0;
      end
    end
  end

  // next state; interrupts take priority over dma, dma over queued work
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (irq_pend) begin
          state_nxt = ST_IAK;
        end else if (event_pend_r && irq_ok) begin
          state_nxt = ST_EVENT;
        end else if (dma_mastership_request) begin
          state_nxt = ST_DMA;
        end else if (q_valid) begin
          state_nxt = ST_ADDR;
        end
      end
      // address out, sync rises next
      ST_ADDR: state_nxt = ST_SETTLE;
      // data settles before the strobe
      ST_SETTLE: begin
        if (cnt_r == '0) begin
          state_nxt = ST_STROBE;
        end
      end
      // wait for the slave reply
      ST_STROBE: begin
        if (slave_reply) begin
          state_nxt = is_write ? ST_END : ST_DESKEW;
        end
      end
      // let read data settle behind reply
      ST_DESKEW: begin
        if (cnt_r == '0) begin
          state_nxt = ST_END;
        end
      end
      // drop strobe, then sync once reply goes
      ST_END: begin
        if (!slave_reply) begin
          state_nxt = ST_IDLE;
        end
      end
      // acknowledge cycle waits for vector reply
      ST_IAK: begin
        if (slave_reply) begin
          state_nxt = ST_IAK_DESKEW;
        end
      end
      ST_IAK_DESKEW: begin
        if (cnt_r == '0) begin
          state_nxt = ST_END;
        end
      end
      // bus granted until the dma device lets go
      ST_DMA: begin
        if (!dma_mastership_request && !dma_select_ack) begin
          state_nxt = ST_IDLE;
        end
      end
      // internal event vector, no bus cycle
      ST_EVENT: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // deskew timer, loaded on entry to a timed state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (state_r == ST_ADDR) begin
      cnt_r <= CNT_W'(OUT_DESKEW);
    end else if ((state_r == ST_STROBE || state_r == ST_IAK) && slave_reply) begin
      cnt_r <= CNT_W'(IN_DESKEW - 1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // latch the request at the queue pop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_r <= '0;
    end else if (q_take) begin
      cur_r <= q_data;
    end
  end

  // line drive: address stays through the sync edge, write data after
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_address_lines_out <= '0;
      data_address_lines_oe <= 1'b0;
    end else if (q_take) begin
      data_address_lines_out <= q_data[DATA_W +: ADDR_W];
      data_address_lines_oe <= 1'b1;
    end else if (state_r == ST_SETTLE && is_write) begin
      data_address_lines_out <= {{(ADDR_W-DATA_W){1'b0}}, cur_r[DATA_W-1:0]};
      data_address_lines_oe <= 1'b1;
    end else if (state_r == ST_SETTLE) begin
      data_address_lines_oe <= 1'b0; // release for read data
    end else if (state_nxt == ST_IDLE) begin
      data_address_lines_oe <= 1'b0;
    end
  end

  // sync: raised after address is out, held until transfer end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      transfer_sync <= 1'b0;
    end else if (state_r == ST_ADDR) begin
      transfer_sync <= 1'b1;
    end else if (state_r == ST_END && !slave_reply && !int_ack_out) begin
      transfer_sync <= 1'b0;
    end
  end

  // write/byte: at sync edge for writes, again in strobe for bytes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_byte_select <= 1'b0;
    end else if (state_r == ST_ADDR) begin
      write_byte_select <= is_write;
    end else if (state_r == ST_SETTLE) begin
      // dropped between sync edge and strobe
      write_byte_select <= (cnt_r == '0) && is_byte;
    end else if (state_r != ST_STROBE) begin
      write_byte_select <= 1'b0;
    end
  end

  // data-out strobe only after the settle count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_out_strobe <= 1'b0;
    end else if (state_r == ST_SETTLE && cnt_r == '0 && is_write) begin
      data_out_strobe <= 1'b1;
    end else if (state_r == ST_STROBE && slave_reply) begin
      data_out_strobe <= 1'b0;
    end
  end

  // data-in strobe for reads with sync, or for acknowledge without
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_in_strobe <= 1'b0;
    end else if (state_r == ST_SETTLE && cnt_r == '0 && !is_write) begin
      data_in_strobe <= 1'b1;
    end else if (state_r == ST_IDLE && irq_pend) begin
      data_in_strobe <= 1'b1;
    end else if ((state_r == ST_DESKEW || state_r == ST_IAK_DESKEW) && cnt_r == '0) begin
      data_in_strobe <= 1'b0;
    end
  end

  // acknowledge out to the nearest device, dropped with the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_ack_out <= 1'b0;
    end else if (state_r == ST_IDLE && irq_pend) begin
      int_ack_out <= 1'b1;
    end else if (state_r == ST_IAK_DESKEW && cnt_r == '0) begin
      int_ack_out <= 1'b0;
    end
  end

  // dma grant out while in the dma state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dma_grant_out <= 1'b0;
    end else begin
      // grant is withdrawn once the device takes the bus
      dma_grant_out <= (state_nxt == ST_DMA) && !dma_select_ack;
    end
  end

  // response: read data or vector sampled at deskew end, writes at reply
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_code <= RSP_READ;
      rsp_data <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_r == ST_DESKEW && cnt_r == '0) begin
        rsp_valid <= 1'b1;
        rsp_code <= RSP_READ;
        rsp_data <= data_address_lines_in[DATA_W-1:0];
      end else if (state_r == ST_IAK_DESKEW && cnt_r == '0) begin
        rsp_valid <= 1'b1;
        rsp_code <= RSP_VECTOR;
        rsp_data <= data_address_lines_in[DATA_W-1:0];
      end else if (state_r == ST_STROBE && slave_reply && is_write) begin
        rsp_valid <= 1'b1;
        rsp_code <= RSP_WRITE;
        rsp_data <= cur_r[DATA_W-1:0];
      end else if (state_r == ST_EVENT) begin
        rsp_valid <= 1'b1;
        rsp_code <= RSP_EVENT;
        rsp_data <= EVENT_VECTOR;
      end
    end
  end

  // bus initialize mirrors reset, registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_initialize <= 1'b1;
    end else begin
      bus_initialize <= 1'b0;
    end
  end
endmodule

// *** abt_pkg.sv ***
/*
  abt_pkg: shared constants for the asynchronous backplane bus master
  (processor end). Holds field positions, widths, vectors, codes and
  deskew timing counts. Assumes a 125 MHz mclk.
*/
package abt_pkg;
  // clock period in picoseconds
  localparam int CLK_PERIOD_PS = 8000;
  // address and data widths on the multiplexed lines
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  // status word bit that masks interrupts
  localparam int PSW_PRIO_BIT = 7;
  // vector for the external event request (100 octal)
  localparam logic [15:0] EVENT_VECTOR = 16'h0040;
  // deskew: data settle before strobe, and read data after reply
  localparam int DESKEW_OUT_NS = 150;
  localparam int DESKEW_IN_NS = 200;
  // least times round up to whole cycles, never below one
  localparam int DESKEW_OUT_CYC = ((DESKEW_OUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((DESKEW_OUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int DESKEW_IN_CYC = ((DESKEW_IN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((DESKEW_IN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // counter width for the deskew timer
  localparam int CNT_W = 8;
  // request fifo depth and word layout: {kind[1:0], addr, data}
  localparam int FIFO_DEPTH = 8;
  localparam int REQ_W = 2 + ADDR_W + DATA_W;
  // request kinds
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_WORD_WRITE = 2'h1;
  localparam logic [1:0] KIND_BYTE_WRITE = 2'h2;
  // response codes to the user
  localparam logic [1:0] RSP_READ = 2'h0;
  localparam logic [1:0] RSP_WRITE = 2'h1;
  localparam logic [1:0] RSP_VECTOR = 2'h2;
  localparam logic [1:0] RSP_EVENT = 2'h3;
endpackage

// *** abt_fifo.sv ***
/*
  abt_fifo: small synchronous fifo in flip-flops with valid/ready on
  both sides. Assumes one clock and an active-high async reset.
*/
`timescale 1ns/10ps
module abt_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // refuse depths the pointer logic cannot serve
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("abt_fifo depth must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH]; // storage words
  logic [AW:0] wr_ptr_r; // write pointer with wrap bit
  logic [AW:0] rd_ptr_r; // read pointer with wrap bit
  logic push; // word accepted
  logic pop; // word taken
  logic [AW:0] wr_ptr_nxt; // write pointer after this edge
  logic [AW:0] rd_ptr_nxt; // read pointer after this edge
  logic full_r; // registered full, so ready comes from a flop

  // ready is a flop output; full is worked out from the next pointers
  assign in_ready = !full_r;
  assign wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
  assign rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer update
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      full_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      // full when pointers differ only in the wrap bit
      full_r <= (wr_ptr_nxt[AW] != rd_ptr_nxt[AW]) && (wr_ptr_nxt[AW-1:0] == rd_ptr_nxt[AW-1:0]);
    end
  end

  // storage write; no reset needed for data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// *** abt_master_checker.sv ***
/*
  abt_master_checker: bus protocol assertions on the abt_master ports.
  assumes deskew counts of at least two cycles; bound to every abt_master.
*/
`timescale 1ns/10ps
module abt_master_checker
  import abt_pkg::*;
#(
  parameter int OUT_DESKEW = 2,
  parameter int IN_DESKEW = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // status and requests
  input wire logic [15:0] processor_status_word,
  input wire logic irq_level_four,
  input wire logic irq_level_seven,
  input wire logic slave_reply,
  // bus outputs
  input wire logic [ADDR_W-1:0] data_address_lines_out,
  input wire logic data_address_lines_oe,
  input wire logic transfer_sync,
  input wire logic data_in_strobe,
  input wire logic data_out_strobe,
  input wire logic write_byte_select,
  input wire logic int_ack_out,
  // user response
  input wire logic rsp_valid,
  input wire logic [1:0] rsp_code,
  input wire logic [DATA_W-1:0] rsp_data
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_addr_before_sync: assert property ($rose(transfer_sync) |->
    $past(data_address_lines_oe) && data_address_lines_oe && $stable(data_address_lines_out))
    else $error("sync rose with no address driven");
  chk_sync_wbs_lead: assert property ($rose(transfer_sync) |=> data_address_lines_oe == $past(write_byte_select))
    else $error("write select wrong at sync edge");
  chk_out_settle: assert property ($rose(data_out_strobe) |->
    $stable(data_address_lines_out) && data_address_lines_oe && $past(transfer_sync, OUT_DESKEW))
    else $error("output strobe before data settled");
  chk_strobe_in_sync: assert property (data_out_strobe || (data_in_strobe && !int_ack_out) |-> transfer_sync)
    else $error("data strobe outside sync");
  chk_ack_no_sync: assert property (int_ack_out |-> data_in_strobe && !transfer_sync)
    else $error("acknowledge without bare input strobe");
  chk_ack_masked: assert property ($rose(int_ack_out) |->
    !$past(processor_status_word[7]) && ($past(irq_level_four) || $past(irq_level_seven)))
    else $error("acknowledge while masked or unrequested");
  chk_in_deskew: assert property (rsp_valid && (rsp_code == RSP_READ || rsp_code == RSP_VECTOR) |->
    $past(slave_reply, IN_DESKEW))
    else $error("read data taken before deskew");
  chk_sync_end: assert property ($fell(transfer_sync) |-> !slave_reply && !data_in_strobe && !data_out_strobe)
    else $error("sync ended early");
  chk_event_vector: assert property (rsp_valid && rsp_code == RSP_EVENT |-> rsp_data == 16'h0040)
    else $error("wrong event vector");
  // main scenarios reached
  cover property (data_out_strobe && write_byte_select);
  cover property (rsp_valid && rsp_code == RSP_READ);
  cover property (rsp_valid && rsp_code == RSP_VECTOR);
  cover property (rsp_valid && rsp_code == RSP_EVENT);
endmodule
bind abt_master abt_master_checker #(.OUT_DESKEW(OUT_DESKEW), .IN_DESKEW(IN_DESKEW)) abt_master_checker_i (.*);

// *** abt_slave_model.sv ***
/*
  abt_slave_model: behavioural bus slave and interrupting device.
  assumes active-high levels; forms the wired data lines for the master.
*/
`timescale 1ns/10ps
module abt_slave_model #(
  parameter logic [15:0] VEC = 16'h00b0 // vector handed out on acknowledge
) (
  // clock, initialize and latency
  input wire logic mclk,
  input wire logic binit,
  input wire logic [7:0] delay,
  // master lines
  input wire logic sync,
  input wire logic din,
  input wire logic dout,
  input wire logic ack,
  input wire logic wbs,
  input wire logic [17:0] lines_out,
  input wire logic oe,
  // slave side
  output logic reply,
  output logic [17:0] lines_in,
  output logic [15:0] wr_data,
  output logic wr_byte
);
  logic [17:0] addr_r, last_r; // latched address, last wire level
  logic [15:0] drv_r;
  logic drv_en;
  logic [7:0] cnt;
  // released lines show a changing value, never a stale one
  assign lines_in = oe ? lines_out : (drv_en ? {2'h0, drv_r} : ~last_r);
  // address latch and reply handshake
  always @(posedge mclk) begin
    last_r <= lines_in;
    if (binit) begin
      reply <= 1'b0;
      drv_en <= 1'b0;
      cnt <= 8'h00;
    end else if ((din || dout) && !reply) begin
      cnt <= cnt + 8'h01;
      if (cnt >= delay) begin
        reply <= 1'b1;
        if (din) begin
          drv_en <= 1'b1;
          drv_r <= ack ? VEC : addr_r[15:0] ^ 16'ha5a5;
        end else begin
          wr_data <= lines_out[15:0];
          wr_byte <= wbs;
        end
      end
    end else if (!din && !dout) begin
      reply <= 1'b0;
      drv_en <= 1'b0;
      cnt <= 8'h00;
      if (oe && !sync) addr_r <= lines_out;
    end
  end
endmodule

// *** abt_master_tb_top.sv ***
/*
  abt_master_tb_top: self-checking bench for abt_master and its queue.
  assumes the slave model on the far side; deskew counts shortened to two.
*/
`timescale 1ns/10ps
module abt_master_tb_top;
  import abt_pkg::*;
  localparam int DSK = 2; // short deskew keeps the run brief
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid, req_ready, rsp_valid, oe, sync, din, dout, wbs, reply, ack, binit, wr_byte;
  logic irq4, irq7, evt, dreq, dgnt, dsack;
  logic [1:0] req_kind, rsp_code;
  logic [17:0] req_addr, lin, lout;
  logic [15:0] req_wdata, rsp_data, wr_data, psw;
  logic [7:0] delay;
  logic [17:0] rq[$]; // collected {code, data}
  int fail_count = 0;
  int checks_done = 0;
  always #4 mclk = ~mclk;
  abt_master #(.OUT_DESKEW(DSK), .IN_DESKEW(DSK)) abt_master_i (.mclk(mclk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_data(rsp_data),
    .processor_status_word(psw), .data_address_lines_in(lin), .data_address_lines_out(lout),
    .data_address_lines_oe(oe), .transfer_sync(sync), .data_in_strobe(din), .data_out_strobe(dout),
    .write_byte_select(wbs), .slave_reply(reply), .irq_level_four(irq4), .irq_level_seven(irq7),
    .external_event_request(evt), .int_ack_out(ack), .dma_mastership_request(dreq),
    .dma_grant_out(dgnt), .dma_select_ack(dsack), .bus_initialize(binit));
  abt_slave_model abt_slave_model_i (.mclk(mclk), .binit(binit), .delay(delay), .sync(sync),
    .din(din), .dout(dout), .ack(ack), .wbs(wbs), .lines_out(lout), .oe(oe), .reply(reply),
    .lines_in(lin), .wr_data(wr_data), .wr_byte(wr_byte));
  // response pulses last one cycle, so catch each one
  always @(posedge mclk) if (rsp_valid === 1'b1) rq.push_back({rsp_code, rsp_data});
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [17:0] exp, input logic [17:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // bounded wait for the next response, then compare it
  task automatic get_rsp(input logic [1:0] c, input logic [15:0] d, input bit dd);
    logic [17:0] r;
    for (int n = 0; n < 400 && rq.size() == 0; n++) @(posedge mclk);
    r = (rq.size() > 0) ? rq.pop_front() : 18'hx;
    check({16'h0, c}, {16'h0, r[17:16]});
    if (dd) check({2'h0, d}, {2'h0, r[15:0]});
  endtask
  // offer one request, held until taken
  task automatic push(input logic [1:0] k, input logic [17:0] a, input logic [15:0] d);
    @(negedge mclk);
    req_valid = 1'b1;
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    for (int n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
  endtask
  task automatic t_write(input logic [1:0] k, input logic [17:0] a, input logic [15:0] d);
    push(k, a, d);
    get_rsp(RSP_WRITE, d, 1'b1);
    check({2'h0, d}, {2'h0, wr_data});
    check({17'h0, k == KIND_BYTE_WRITE}, {17'h0, wr_byte});
  endtask
  task automatic t_read(input logic [17:0] a);
    push(KIND_READ, a, 16'h0);
    get_rsp(RSP_READ, a[15:0] ^ 16'ha5a5, 1'b1);
  endtask
  // stalled slave: fill the queue until refused, then drain it
  task automatic t_fill();
    int n;
    delay = 8'd30;
    @(negedge mclk);
    req_valid = 1'b1;
    req_kind = KIND_WORD_WRITE;
    for (n = 0; n < 12 && req_ready === 1'b1; n++) begin
      req_addr = 18'(n);
      req_wdata = 16'h1000 + 16'(n);
      @(negedge mclk);
    end
    req_valid = 1'b0;
    check(18'h0, {17'h0, req_ready});
    check(18'h1, {17'h0, n >= FIFO_DEPTH});
    for (int i = 0; i < n; i++) get_rsp(RSP_WRITE, 16'h0, 1'b0);
    check({2'h0, 16'h1000 + 16'(n - 1)}, {2'h0, wr_data});
    delay = 8'd1;
  endtask
  // masked request first, then acknowledged once unmasked
  task automatic t_irq(input bit seven);
    @(negedge mclk);
    psw = 16'h0080;
    irq4 = !seven;
    irq7 = seven;
    repeat (20) @(negedge mclk);
    check(18'h0, {17'h0, ack});
    psw = 16'h0000;
    for (int n = 0; n < 50 && ack !== 1'b1; n++) @(negedge mclk);
    check(18'h1, {17'h0, ack});
    irq4 = 1'b0;
    irq7 = 1'b0;
    get_rsp(RSP_VECTOR, 16'h00b0, 1'b1);
    repeat (20) @(negedge mclk);
    check(18'h0, 18'(rq.size()));
  endtask
  task automatic t_event();
    psw = 16'h0080;
    @(negedge mclk);
    evt = 1'b1;
    @(negedge mclk);
    evt = 1'b0;
    repeat (10) @(negedge mclk);
    check(18'h0, 18'(rq.size()));
    psw = 16'h0000;
    get_rsp(RSP_EVENT, 16'h0040, 1'b1);
  endtask
  task automatic t_dma();
    @(negedge mclk);
    dreq = 1'b1;
    for (int n = 0; n < 50 && dgnt !== 1'b1; n++) @(negedge mclk);
    check(18'h1, {17'h0, dgnt});
    dsack = 1'b1;
    dreq = 1'b0;
    @(negedge mclk);
    check(18'h0, {17'h0, dgnt});
    dsack = 1'b0;
  endtask
  initial begin
    {req_valid, irq4, irq7, evt, dreq, dsack} = 6'h00;
    req_kind = 2'h0;
    req_addr = 18'h0;
    req_wdata = 16'h0;
    psw = 16'h0;
    delay = 8'd1;
    repeat (16) @(negedge mclk);
    check(18'h1, {17'h0, binit});
    check(18'h1, {17'h0, req_ready});
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    check(18'h0, {17'h0, binit});
    t_write(KIND_WORD_WRITE, 18'h2_1234, 16'hbeef);
    t_write(KIND_BYTE_WRITE, 18'h3_ffff, 16'h00a5);
    t_read(18'h0_0000);
    t_read(18'h3_ffff);
    t_fill();
    t_irq(1'b0);
    t_irq(1'b1);
    t_event();
    t_dma();
    t_read(18'h1_5555);
    finish_test();
  end
  // watchdog far beyond the expected run length
  initial begin
    #(20000 * 8);
    fail_count++;
    finish_test();
  end
endmodule
